/* File: rtl/ddp_datapath.sv */
// Purpose: Dual fixed-point data path with operand registers and accumulators
// Assumes: One command per clock, taken when cmd.valid is high
// Notes: Results appear one clock after the command
// Operation
// - Each of two paths holds four 32-bit operand registers and four 72-bit accumulators.
// - An accumulator is guard (8), high (32) and low (32) parts, each readable and writable.
// - Both paths share one multiply-accumulate unit, output stage and logic unit, used by the path a command names.
// - The core connects to an X data bus, a Y data bus and a program memory bus.
// - Operands are 1.31 fractions from 0x80000000 (-1.0) to 0x7fffffff.
// - The accumulator is a sign bit, 8 integer bits and 63 fraction bits.
// - The 64-bit readout is a sign bit and 63 fraction bits.
// - All path arithmetic and logic works on the full 72 bits.
// - Operand registers hold 32 bits; whole accumulators leave only via the output stage.
// - Guard bits keep sums beyond the 32-bit range exactly.
// - A 32-bit load goes to the high part, sign into guard, low cleared.
// - A 64-bit load puts X sign-extended in high and guard and Y unchanged in low.
// - Products of 1.31 operands are shifted left one bit to form 1.63.
// - A whole-accumulator read saturates to the limits and sets the limit flag.
// - Part reads and the bitwise accumulator move bypass the output stage.
`timescale 1ns/1ps
module ddp_datapath
   import ddp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ddp_cmd_t cmd,
   input wire logic [DDP_WORD_W-1:0] x_bus_in,
   input wire logic [DDP_WORD_W-1:0] y_bus_in,
   output ddp_res_t result,
   output logic limit_flag,
   output logic [DDP_PROG_W-1:0] prog_addr
);
   // ***************************************************
   // Functions
   // ***************************************************
   function automatic logic [DDP_ACC_W-1:0] sext_word(input logic [DDP_WORD_W-1:0] w);
      return {{DDP_GUARD_W{w[DDP_WORD_W-1]}}, w, DDP_LOW_ZERO};
   endfunction : sext_word

   function automatic logic [DDP_ACC_W-1:0] frac_product(input logic [DDP_WORD_W-1:0] a,
                                                       input logic [DDP_WORD_W-1:0] b);
      logic signed [DDP_LONG_W-1:0] p;
      p = $signed(a) * $signed(b);
      return {{(DDP_GUARD_W-1){p[DDP_LONG_W-1]}}, p, 1'b0};
   endfunction : frac_product

   function automatic logic acc_fits(input logic [DDP_ACC_W-1:0] a);
      return (a[DDP_SIGN_BIT:DDP_LONG_SIGN] == '0) || (a[DDP_SIGN_BIT:DDP_LONG_SIGN] == '1);
   endfunction : acc_fits

   function automatic logic [DDP_WORD_W-1:0] sat_word(input logic [DDP_ACC_W-1:0] a);
      if (acc_fits(a)) begin
         return a[DDP_HIGH_LSB +: DDP_WORD_W];
      end
      return a[DDP_SIGN_BIT] ? DDP_FRAC_MIN : DDP_FRAC_MAX;
   endfunction : sat_word

   function automatic logic [DDP_LONG_W-1:0] sat_long(input logic [DDP_ACC_W-1:0] a);
      if (acc_fits(a)) begin
         return a[DDP_LONG_W-1:0];
      end
      return a[DDP_SIGN_BIT] ? DDP_LONG_MIN : DDP_LONG_MAX;
   endfunction : sat_long

   // ***************************************************
   // Storage
   // ***************************************************
   logic [DDP_ACC_W-1:0] acc_reg [DDP_NPATH][DDP_NREG];
   logic [DDP_WORD_W-1:0] opr_reg [DDP_NPATH][DDP_NREG];
   ddp_res_t res_reg;
   logic limit_reg;
   logic [DDP_PROG_W-1:0] prog_reg;

   logic [DDP_ACC_W-1:0] sel_acc;
   logic [DDP_ACC_W-1:0] src_acc;
   logic [DDP_ACC_W-1:0] mv_acc;
   logic [DDP_ACC_W-1:0] prod;
   logic [DDP_ACC_W-1:0] acc_next;
   logic [DDP_WORD_W-1:0] bus_word;
   logic acc_wr;
   logic acc_read;

   assign sel_acc = acc_reg[cmd.path][cmd.dst];
   assign src_acc = acc_reg[cmd.path][cmd.src_a];
   assign mv_acc = acc_reg[cmd.src_path][cmd.src_a];
   assign prod = frac_product(opr_reg[cmd.path][cmd.src_a], opr_reg[cmd.path][cmd.src_b]);
   assign bus_word = cmd.from_y ? y_bus_in : x_bus_in;
   assign acc_read = cmd.valid && ((cmd.op == OP_ACC_READ32) || (cmd.op == OP_ACC_READ64));

   // ***************************************************
   // Accumulator update: shared MAC and logic unit for the selected path
   // ***************************************************
   always_comb begin
      acc_next = sel_acc;
      acc_wr = cmd.valid;
      case (cmd.op)
         OP_ACC_LOAD32: acc_next = sext_word(bus_word);
         OP_ACC_LOAD64: begin
            acc_next = sext_word(x_bus_in);
            acc_next[DDP_LOW_LSB +: DDP_WORD_W] = y_bus_in;
         end
         OP_PART_WRITE: begin
            case (cmd.part)
               PART_GUARD: acc_next[DDP_GUARD_LSB +: DDP_GUARD_W] = bus_word[DDP_GUARD_W-1:0];
               PART_HIGH: acc_next[DDP_HIGH_LSB +: DDP_WORD_W] = bus_word;
               PART_LOW: acc_next[DDP_LOW_LSB +: DDP_WORD_W] = bus_word;
               default: acc_wr = 1'b0;
            endcase
         end
         OP_MPY: acc_next = prod;
         OP_MAC: acc_next = sel_acc + prod;
         OP_MSU: acc_next = sel_acc - prod;
         OP_ADD: acc_next = sel_acc + src_acc;
         OP_SUB: acc_next = sel_acc - src_acc;
         OP_AND: acc_next = sel_acc & src_acc;
         OP_OR: acc_next = sel_acc | src_acc;
         OP_XOR: acc_next = sel_acc ^ src_acc;
         OP_ACC_MOVE: acc_next = mv_acc;
         OP_ACC_CLEAR: acc_next = DDP_ACC_RST;
         default: acc_wr = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < DDP_NPATH; p++) begin
            for (int i = 0; i < DDP_NREG; i++) begin
               acc_reg[p][i] <= DDP_ACC_RST;
            end
         end
      end else if (acc_wr) begin
         acc_reg[cmd.path][cmd.dst] <= acc_next;
      end
   end

   // ***************************************************
   // Operand registers
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < DDP_NPATH; p++) begin
            for (int i = 0; i < DDP_NREG; i++) begin
               opr_reg[p][i] <= DDP_WORD_RST;
            end
         end
      end else if (cmd.valid && (cmd.op == OP_REG_LOAD)) begin
         opr_reg[cmd.path][cmd.dst] <= bus_word;
      end
   end

   // ***************************************************
   // Output stage and bus results
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         res_reg <= '0;
      end else begin
         res_reg.valid <= 1'b0;
         if (cmd.valid) begin
            case (cmd.op)
               OP_REG_READ: begin
                  res_reg.valid <= 1'b1;
                  res_reg.x_data <= opr_reg[cmd.path][cmd.src_a];
               end
               OP_PART_READ: begin
                  res_reg.valid <= 1'b1;
                  case (cmd.part)
                     PART_GUARD: res_reg.x_data <=
                        {{(DDP_WORD_W-DDP_GUARD_W){1'b0}}, sel_acc[DDP_GUARD_LSB +: DDP_GUARD_W]};
                     PART_HIGH: res_reg.x_data <= sel_acc[DDP_HIGH_LSB +: DDP_WORD_W];
                     default: res_reg.x_data <= sel_acc[DDP_LOW_LSB +: DDP_WORD_W];
                  endcase
               end
               OP_ACC_READ32: begin
                  res_reg.valid <= 1'b1;
                  if (cmd.from_y) begin
                     res_reg.y_data <= sat_word(sel_acc);
                  end else begin
                     res_reg.x_data <= sat_word(sel_acc);
                  end
               end
               OP_ACC_READ64: begin
                  res_reg.valid <= 1'b1;
                  {res_reg.x_data, res_reg.y_data} <= sat_long(sel_acc);
               end
               default: res_reg.valid <= 1'b0;
            endcase
         end
      end
   end

   // ***************************************************
   // Limit flag: saturation sets, clear command clears, set wins
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         limit_reg <= 1'b0;
      end else if (acc_read && !acc_fits(sel_acc)) begin
         limit_reg <= 1'b1;
      end else if (cmd.valid && (cmd.op == OP_LIMIT_CLEAR)) begin
         limit_reg <= 1'b0;
      end
   end

   // ***************************************************
   // Program memory address
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_reg <= DDP_PROG_RST;
      end else if (cmd.valid) begin
         prog_reg <= prog_reg + DDP_PROG_STEP;
      end
   end

   assign result = res_reg;
   assign limit_flag = limit_reg;
   assign prog_addr = prog_reg;

   // ***************************************************
   // Checks
   // ***************************************************
   ddp_cmd_t last_cmd;
   logic [DDP_WORD_W-1:0] last_x;
   logic [DDP_WORD_W-1:0] last_y;
   logic [DDP_ACC_W-1:0] last_acc;
   logic [DDP_ACC_W-1:0] last_src;

   always_ff @(posedge clk) begin
      if (rst) begin
         last_cmd <= '0;
      end else begin
         last_cmd <= cmd;
      end
      last_x <= x_bus_in;
      last_y <= y_bus_in;
      last_acc <= sel_acc;
      last_src <= src_acc;
   end

   a_load32_sext: assert property (@(posedge clk) disable iff (rst)
      (last_cmd.valid && last_cmd.op == OP_ACC_LOAD32 && !last_cmd.from_y) |->
      acc_reg[last_cmd.path][last_cmd.dst] == {{8{last_x[31]}}, last_x, 32'h0000_0000})
      else $error("32-bit load not sign extended");

   a_load64_split: assert property (@(posedge clk) disable iff (rst)
      (last_cmd.valid && last_cmd.op == OP_ACC_LOAD64) |->
      acc_reg[last_cmd.path][last_cmd.dst] == {{8{last_x[31]}}, last_x, last_y})
      else $error("64-bit load misplaced");

   a_part_keep: assert property (@(posedge clk) disable iff (rst)
      (last_cmd.valid && last_cmd.op == OP_PART_WRITE && last_cmd.part == PART_HIGH) |->
      (acc_reg[last_cmd.path][last_cmd.dst][71:64] == last_acc[71:64]) &&
      (acc_reg[last_cmd.path][last_cmd.dst][31:0] == last_acc[31:0]))
      else $error("part write disturbed other parts");

   a_mpy_align: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_MPY && cmd.src_a == 2'd0 && cmd.src_b == 2'd0 &&
       opr_reg[cmd.path][0] == 32'h8000_0000) |=>
      acc_reg[last_cmd.path][last_cmd.dst] == 72'h00_8000_0000_0000_0000)
      else $error("product of -1 by -1 not aligned to +1.0");

   a_sat_high: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_ACC_READ32 && !cmd.from_y && !sel_acc[71] &&
       sel_acc[71:63] != 9'h000) |=> (result.x_data == 32'h7fff_ffff) && limit_flag)
      else $error("positive overflow not saturated");

   a_sat_pass: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_ACC_READ32 && cmd.from_y && sel_acc[71:63] == 9'h1ff) |=>
      result.y_data == $past(sel_acc[63:32]) && result.valid)
      else $error("in-range read altered");

   a_limit_sticky: assert property (@(posedge clk) disable iff (rst)
      (limit_flag && !(cmd.valid && cmd.op == OP_LIMIT_CLEAR)) |=> limit_flag)
      else $error("limit flag lost");

   a_part_bypass: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_PART_READ && cmd.part == PART_HIGH) |=>
      result.x_data == last_acc[63:32])
      else $error("part read went through saturation");

   a_wide_add: assert property (@(posedge clk) disable iff (rst)
      (last_cmd.valid && last_cmd.op == OP_ADD) |->
      acc_reg[last_cmd.path][last_cmd.dst] == last_acc + last_src)
      else $error("72-bit add wrong");

   a_sat_low: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_ACC_READ64 && sel_acc[71] && sel_acc[71:63] != 9'h1ff) |=>
      ({result.x_data, result.y_data} == 64'h8000_0000_0000_0000) && limit_flag)
      else $error("negative overflow not saturated");

   a_move_bitwise: assert property (@(posedge clk) disable iff (rst)
      (last_cmd.valid && last_cmd.op == OP_ACC_MOVE) |->
      acc_reg[last_cmd.path][last_cmd.dst] == $past(mv_acc))
      else $error("accumulator move altered bits");

   a_mpy_shift: assert property (@(posedge clk) disable iff (rst)
      (cmd.valid && cmd.op == OP_MPY) |=> !acc_reg[last_cmd.path][last_cmd.dst][0])
      else $error("product not shifted left");
endmodule : ddp_datapath

/* File: rtl/ddp_pkg.sv */
// Purpose: Shared constants and types for the dual fixed-point data path
// Assumes: One core clock, synchronous active-high reset
// Notes: Accumulator layout is guard | high | low, sign at the top bit
package ddp_pkg;
   // ***************************************************
   // Widths and field positions
   // ***************************************************
   localparam int DDP_NPATH = 2;
   localparam int DDP_NREG = 4;
   localparam int DDP_WORD_W = 32;
   localparam int DDP_GUARD_W = 8;
   localparam int DDP_LONG_W = 64;
   localparam int DDP_ACC_W = 72;
   localparam int DDP_LOW_LSB = 0;
   localparam int DDP_HIGH_LSB = 32;
   localparam int DDP_GUARD_LSB = 64;
   localparam int DDP_SIGN_BIT = 71;
   localparam int DDP_LONG_SIGN = 63;
   localparam int DDP_PROG_W = 16;

   // ***************************************************
   // Limits and reset values
   // ***************************************************
   localparam logic [31:0] DDP_FRAC_MAX = 32'h7fff_ffff;
   localparam logic [31:0] DDP_FRAC_MIN = 32'h8000_0000;
   localparam logic [63:0] DDP_LONG_MAX = 64'h7fff_ffff_ffff_ffff;
   localparam logic [63:0] DDP_LONG_MIN = 64'h8000_0000_0000_0000;
   localparam logic [71:0] DDP_ACC_RST = 72'h00_0000_0000_0000_0000;
   localparam logic [31:0] DDP_WORD_RST = 32'h0000_0000;
   localparam logic [31:0] DDP_LOW_ZERO = 32'h0000_0000;
   localparam logic [15:0] DDP_PROG_RST = 16'h0000;
   localparam logic [15:0] DDP_PROG_STEP = 16'h0001;

   // ***************************************************
   // Commands and carriers
   // ***************************************************
   typedef enum logic [4:0] {
      OP_NOP, OP_REG_LOAD, OP_REG_READ, OP_ACC_LOAD32, OP_ACC_LOAD64,
      OP_PART_WRITE, OP_PART_READ, OP_ACC_READ32, OP_ACC_READ64,
      OP_MPY, OP_MAC, OP_MSU, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
      OP_ACC_MOVE, OP_ACC_CLEAR, OP_LIMIT_CLEAR
   } ddp_op_t;

   typedef enum logic [1:0] {
      PART_GUARD, PART_HIGH, PART_LOW
   } ddp_part_t;

   typedef struct packed {
      logic valid;
      ddp_op_t op;
      logic path;
      logic [1:0] dst;
      logic [1:0] src_a;
      logic [1:0] src_b;
      logic src_path;
      logic from_y;
      ddp_part_t part;
   } ddp_cmd_t;

   typedef struct packed {
      logic valid;
      logic [31:0] x_data;
      logic [31:0] y_data;
   } ddp_res_t;
endpackage : ddp_pkg

/* File: tb/ddp_testbench.sv */
// Purpose: Self-checking bench for the dual fixed-point data path
// Assumes: A command is taken one edge after it is driven; reads answer one clock later
// Notes: Expected values are worked out by hand from the fraction formats
`timescale 1ns/1ps
module testbench
   import ddp_pkg::*;
;
   // ***************************************************
   // Signals and bookkeeping
   // ***************************************************
   logic clk;
   logic rst;
   ddp_cmd_t cmd;
   logic [31:0] x_bus_in;
   logic [31:0] y_bus_in;
   ddp_res_t result;
   logic limit_flag;
   logic [15:0] prog_addr;
   logic [15:0] n_cmd;
   int n_fail;
   int tests_run;

   ddp_datapath u_dut (
      .clk(clk),
      .rst(rst),
      .cmd(cmd),
      .x_bus_in(x_bus_in),
      .y_bus_in(y_bus_in),
      .result(result),
      .limit_flag(limit_flag),
      .prog_addr(prog_addr)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk

   task automatic send(input ddp_op_t op, input logic p, input logic [1:0] d,
         input logic [1:0] a, input logic [1:0] b, input logic sp, input logic fy,
         input ddp_part_t pt, input logic [31:0] xv, input logic [31:0] yv);
      @(posedge clk);
      cmd <= '{1'b1, op, p, d, a, b, sp, fy, pt};
      x_bus_in <= xv;
      y_bus_in <= yv;
      n_cmd++;
   endtask : send

   task automatic ld(input ddp_op_t op, input logic p, input logic [1:0] d, input logic fy,
         input ddp_part_t pt, input logic [31:0] xv, input logic [31:0] yv);
      send(op, p, d, 2'd0, 2'd0, 1'b0, fy, pt, xv, yv);
   endtask : ld

   task automatic al(input ddp_op_t op, input logic p, input logic [1:0] d,
         input logic [1:0] a, input logic [1:0] b, input logic sp);
      send(op, p, d, a, b, sp, 1'b0, PART_HIGH, 32'h0000_0000, 32'h0000_0000);
   endtask : al

   // One read, taken at the next edge, answer checked just after that edge
   task automatic ck(input ddp_op_t op, input logic p, input logic [1:0] d,
         input ddp_part_t pt, input logic [63:0] e);
      send(op, p, d, d, 2'd0, 1'b0, 1'b0, pt, 32'h0000_0000, 32'h0000_0000);
      @(posedge clk);
      cmd <= '0;
      #1;
      chk(result.valid, 64'h0001);
      if (op == OP_ACC_READ64) chk({result.x_data, result.y_data}, e);
      else chk(result.x_data, e);
   endtask : ck

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      #1;
      chk({result.valid, limit_flag, prog_addr}, 64'h0000);
   endtask : t_reset

   task automatic t_load();
      ld(OP_ACC_LOAD32, 1'b0, 2'd0, 1'b0, PART_HIGH, 32'h8234_5678, 32'h0000_0000);
      ld(OP_ACC_LOAD64, 1'b0, 2'd1, 1'b0, PART_HIGH, 32'h8000_0001, 32'hdead_beef);
      ld(OP_ACC_LOAD32, 1'b1, 2'd3, 1'b1, PART_HIGH, 32'h0000_0000, 32'h1234_5678);
      ck(OP_PART_READ, 1'b0, 2'd0, PART_GUARD, 64'h0000_00ff);
      ck(OP_PART_READ, 1'b0, 2'd0, PART_LOW, 64'h0000);
      ck(OP_ACC_READ32, 1'b0, 2'd0, PART_HIGH, 64'h8234_5678);
      ck(OP_ACC_READ64, 1'b0, 2'd1, PART_HIGH, 64'h8000_0001_dead_beef);
      ck(OP_ACC_READ32, 1'b1, 2'd3, PART_HIGH, 64'h1234_5678);
      ld(OP_ACC_READ32, 1'b0, 2'd0, 1'b1, PART_HIGH, 32'h0000_0000, 32'h0000_0000);
      @(posedge clk);
      cmd <= '0;
      #1;
      chk({result.x_data, result.y_data}, 64'h1234_5678_8234_5678);
      chk(limit_flag, 64'h0000);
      ld(OP_PART_WRITE, 1'b0, 2'd1, 1'b0, PART_GUARD, 32'h0000_0012, 32'h0000_0000);
      ck(OP_PART_READ, 1'b0, 2'd1, PART_HIGH, 64'h8000_0001);
      ck(OP_PART_READ, 1'b0, 2'd1, PART_LOW, 64'hdead_beef);
      ld(OP_PART_WRITE, 1'b0, 2'd1, 1'b1, PART_HIGH, 32'h0000_0000, 32'h0000_1234);
      ck(OP_PART_READ, 1'b0, 2'd1, PART_HIGH, 64'h0000_1234);
      ck(OP_ACC_READ32, 1'b0, 2'd1, PART_HIGH, 64'h7fff_ffff);
      chk(limit_flag, 64'h0001);
      al(OP_LIMIT_CLEAR, 1'b0, 2'd0, 2'd0, 2'd0, 1'b0);
      ck(OP_PART_READ, 1'b0, 2'd1, PART_GUARD, 64'h0000_0012);
      chk(limit_flag, 64'h0000);
      ld(OP_PART_WRITE, 1'b0, 2'd0, 1'b0, PART_GUARD, 32'h0000_0080, 32'h0000_0000);
      ck(OP_ACC_READ64, 1'b0, 2'd0, PART_HIGH, 64'h8000_0000_0000_0000);
      chk(limit_flag, 64'h0001);
   endtask : t_load

   task automatic t_mac();
      ld(OP_REG_LOAD, 1'b0, 2'd1, 1'b0, PART_HIGH, 32'h7fff_ffff, 32'h0000_0000);
      ld(OP_REG_LOAD, 1'b0, 2'd0, 1'b1, PART_HIGH, 32'h0000_0000, 32'h8000_0000);
      ck(OP_REG_READ, 1'b0, 2'd0, PART_HIGH, 64'h8000_0000);
      al(OP_MPY, 1'b0, 2'd2, 2'd1, 2'd1, 1'b0);
      al(OP_MAC, 1'b0, 2'd2, 2'd1, 2'd1, 1'b0);
      ck(OP_PART_READ, 1'b0, 2'd2, PART_HIGH, 64'hffff_fffc);
      ck(OP_PART_READ, 1'b0, 2'd2, PART_LOW, 64'h0000_0004);
      ck(OP_PART_READ, 1'b0, 2'd2, PART_GUARD, 64'h0000);
      al(OP_MSU, 1'b0, 2'd2, 2'd1, 2'd1, 1'b0);
      ck(OP_ACC_READ64, 1'b0, 2'd2, PART_HIGH, 64'h7fff_fffe_0000_0002);
      al(OP_MPY, 1'b0, 2'd3, 2'd0, 2'd1, 1'b0);
      ck(OP_ACC_READ64, 1'b0, 2'd3, PART_HIGH, 64'h8000_0001_0000_0000);
      al(OP_MPY, 1'b0, 2'd3, 2'd0, 2'd0, 1'b0);
      ck(OP_ACC_READ64, 1'b0, 2'd3, PART_HIGH, 64'h7fff_ffff_ffff_ffff);
   endtask : t_mac

   task automatic t_alu();
      ld(OP_ACC_LOAD32, 1'b1, 2'd0, 1'b0, PART_HIGH, 32'h0f0f_0f0f, 32'h0000_0000);
      ld(OP_ACC_LOAD64, 1'b1, 2'd1, 1'b0, PART_HIGH, 32'hff00_ff00, 32'h1234_5678);
      al(OP_OR, 1'b1, 2'd0, 2'd1, 2'd0, 1'b0);
      ck(OP_PART_READ, 1'b1, 2'd0, PART_GUARD, 64'h0000_00ff);
      al(OP_XOR, 1'b1, 2'd0, 2'd1, 2'd0, 1'b0);
      ck(OP_ACC_READ64, 1'b1, 2'd0, PART_HIGH, 64'h000f_000f_0000_0000);
      al(OP_AND, 1'b1, 2'd0, 2'd1, 2'd0, 1'b0);
      al(OP_ADD, 1'b1, 2'd0, 2'd1, 2'd0, 1'b0);
      ck(OP_ACC_READ64, 1'b1, 2'd0, PART_HIGH, 64'hff00_ff00_1234_5678);
      al(OP_ACC_MOVE, 1'b0, 2'd3, 2'd0, 2'd0, 1'b1);
      ck(OP_PART_READ, 1'b0, 2'd3, PART_GUARD, 64'h0000_00ff);
      al(OP_SUB, 1'b1, 2'd0, 2'd1, 2'd0, 1'b0);
      al(OP_ACC_CLEAR, 1'b1, 2'd1, 2'd0, 2'd0, 1'b0);
      ck(OP_ACC_READ64, 1'b1, 2'd0, PART_HIGH, 64'h0000);
      ck(OP_ACC_READ64, 1'b1, 2'd1, PART_HIGH, 64'h0000);
      ck(OP_ACC_READ64, 1'b0, 2'd3, PART_HIGH, 64'hff00_ff00_1234_5678);
      chk(prog_addr, n_cmd);
   endtask : t_alu

   // ***************************************************
   // Main sequence and watchdog
   // ***************************************************
   initial begin
      rst = 1'b1;
      cmd = '0;
      x_bus_in = 32'h0000_0000;
      y_bus_in = 32'h0000_0000;
      n_cmd = 16'h0000;
      n_fail = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_mac();
      t_alu();
      test_done();
   end

   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      test_done();
   end
endmodule : testbench
